// [verif/banked_data_memory_map_tb_top.sv]
// self-checking bench for the banked data memory decoder and core register bank
`include "bdmm_defines.svh"
module banked_data_memory_map_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock_in = 1'b0;
  logic nrst_in = 1'b0;
  logic por_in = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [10:0] adr = 11'h000;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic ack;
  logic [1:0] bank;
  logic [12:0] pc;
  int mismatches = 0;
  int cmp_count = 0;
  logic [31:0] rd;

  bdmm_top i_dut (.CLOCK_IN(clock_in), .NRST_IN(nrst_in), .POR_IN(por_in),
    .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we), .WB_SEL_IN(4'h1),
    .WB_ADR_IN(adr), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack),
    .BANK_OUT(bank), .PC_OUT(pc));

  always #2.5 clock_in = ~clock_in;

  task automatic results;
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  // classic single cycle; the request stands until ack is seen at an edge
  task automatic acc(input logic w, input logic [6:0] ofs, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {2'b00, ofs, 2'b00};
    wdat <= {24'h00_0000, d};
    do begin
      @(posedge clock_in);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) begin
      mismatches++;
      results();
    end
  endtask : acc

  task automatic rd_chk(input logic [6:0] ofs, input logic [7:0] exp, input string msg);
    acc(1'b0, ofs, 8'h00);
    // upper lanes are compared too, they must read zero
    chk(rd, {24'h00_0000, exp}, msg);
  endtask : rd_chk

  task automatic rst(input logic por);
    @(posedge clock_in);
    nrst_in <= 1'b0;
    por_in <= por;
    repeat (5) @(posedge clock_in);
    nrst_in <= 1'b1;
    por_in <= 1'b0;
  endtask : rst

  task automatic t_por_values;
    rd_chk(`BDMM_OFS_FLAGS, 8'h18, "flags por");
    rd_chk(`BDMM_OFS_PC_LOW, 8'h00, "pcl por");
    rd_chk(`BDMM_OFS_PC_LATCH, 8'h00, "latch por");
    rd_chk(`BDMM_OFS_PERIPHERAL_INTERRUPT_FLAGS_1, 8'h00, "peripheral_interrupt_flags_1 por");
  endtask : t_por_values

  task automatic t_storage_and_holes;
    acc(1'b1, `BDMM_OFS_PORT_A, 8'hc3);
    acc(1'b1, 7'h0d, 8'hff);
    rd_chk(`BDMM_OFS_PORT_A, 8'hc3, "port a hold");
    rd_chk(7'h0d, 8'h00, "hole reads zero");
  endtask : t_storage_and_holes

  // bank switch: shared registers stay visible, bank 1 peripheral slot is empty
  task automatic t_banks;
    acc(1'b1, `BDMM_OFS_POINTER, 8'h5a);
    acc(1'b1, 7'h75, 8'ha5);
    acc(1'b1, 7'h20, 8'h22);
    acc(1'b1, `BDMM_OFS_FLAGS, 8'h20);
    @(posedge clock_in);
    chk({30'h0, bank}, 32'h1, "bank select");
    rd_chk(`BDMM_OFS_POINTER, 8'h5a, "pointer mirror");
    rd_chk(`BDMM_OFS_PORT_A, 8'h00, "bank1 slot empty");
    rd_chk(7'h75, 8'ha5, "shared ram bank1");
    acc(1'b1, 7'h20, 8'h11);
    rd_chk(7'h20, 8'h11, "bank1 ram");
    acc(1'b1, `BDMM_OFS_FLAGS, 8'h40);
    @(posedge clock_in);
    chk({30'h0, bank}, 32'h2, "bank two");
    rd_chk(7'h75, 8'ha5, "shared ram bank2");
    acc(1'b1, `BDMM_OFS_FLAGS, 8'h65);
    @(posedge clock_in);
    chk({30'h0, bank}, 32'h3, "bank three");
    rd_chk(`BDMM_OFS_FLAGS, 8'h7d, "flags mirror");
    acc(1'b1, `BDMM_OFS_FLAGS, 8'h05);
    rd_chk(7'h20, 8'h22, "bank0 ram kept");
  endtask : t_banks

  task automatic t_indirect;
    acc(1'b1, `BDMM_OFS_POINTER, 8'h21);
    acc(1'b1, `BDMM_OFS_INDIRECT, 8'h3c);
    rd_chk(7'h21, 8'h3c, "indirect write");
    acc(1'b1, 7'h21, 8'h96);
    rd_chk(`BDMM_OFS_INDIRECT, 8'h96, "indirect read");
  endtask : t_indirect

  // the latch must not reach the counter until the low byte is written
  task automatic t_pc_latch;
    acc(1'b1, `BDMM_OFS_PC_LATCH, 8'h15);
    @(posedge clock_in);
    chk({19'h0, pc}, 32'h0, "latch alone");
    acc(1'b1, `BDMM_OFS_PC_LOW, 8'h34);
    @(posedge clock_in);
    chk({19'h0, pc}, 32'h1534, "pc load");
  endtask : t_pc_latch

  task automatic t_warm_reset;
    acc(1'b1, `BDMM_OFS_INT_CTRL, 8'h81);
    acc(1'b1, `BDMM_OFS_POINTER, 8'h44);
    rst(1'b0);
    rd_chk(`BDMM_OFS_FLAGS, 8'h05, "flags warm");
    rd_chk(`BDMM_OFS_POINTER, 8'h44, "pointer warm");
    rd_chk(`BDMM_OFS_INT_CTRL, 8'h01, "intctrl warm");
    rd_chk(`BDMM_OFS_PC_LOW, 8'h00, "pcl warm");
  endtask : t_warm_reset

  initial begin
    rst(1'b1);
    t_por_values();
    t_storage_and_holes();
    t_banks();
    t_indirect();
    t_pc_latch();
    t_warm_reset();
    results();
  end
endmodule : banked_data_memory_map_tb_top

// [verilog/bdmm_defines.svh]
// constants for the banked data memory map block
// Operation
// [R1] special-function registers hold last written value
// [R2] unimplemented addresses read zero, ignore writes
// [R3] indirect location redirects through pointer register
// [R4] separate power-on and other-reset values
// [R5] two flag bits choose one of four banks
// [R6] each bank spans 128 byte offsets
// [R7] shared core registers decode in all banks
// [R8] high latch loads counter upper bits on low write
// [R9] offsets 70h-7Fh map to bank 0 RAM
`ifndef BDMM_DEFINES_SVH
`define BDMM_DEFINES_SVH
`define BDMM_OFS_INDIRECT 7'h00
`define BDMM_OFS_TIMER0 7'h01
`define BDMM_OFS_PC_LOW 7'h02
`define BDMM_OFS_FLAGS 7'h03
`define BDMM_OFS_POINTER 7'h04
`define BDMM_OFS_PORT_A 7'h05
`define BDMM_OFS_PORT_B 7'h06
`define BDMM_OFS_PORT_C 7'h07
`define BDMM_OFS_PORT_D 7'h08
`define BDMM_OFS_PORT_E 7'h09
`define BDMM_OFS_PC_LATCH 7'h0a
`define BDMM_OFS_INT_CTRL 7'h0b
`define BDMM_OFS_PERIPHERAL_INTERRUPT_FLAGS_1 7'h0c
`define BDMM_OFS_RAM_LO 7'h20
`define BDMM_OFS_SHARED 7'h70
`define BDMM_OFS_LAST 7'h7f
`define BDMM_RAM_WORDS 128
`define BDMM_FLAGS_POR 8'h18
`define BDMM_FLAGS_KEEP 8'h07
`define BDMM_INT_KEEP 8'h01
`define BDMM_PCL_MASK 8'h1f
`define BDMM_PORT_E_DATA_MASK 8'h0f
`define BDMM_ZERO8 8'h00
`define BDMM_BANK_HI 8
`define BDMM_BANK_LO 7
`endif

// [verilog/bdmm_pkg.sv]
// types for the banked data memory map block
package bdmm_pkg;
  typedef enum logic [1:0] {
    BDMM_IDLE = 2'b00,
    BDMM_ACK = 2'b01
  } bdmm_state_type;
  typedef logic [8:0] bdmm_addr_type;
endpackage : bdmm_pkg

// [verilog/bdmm_ram.sv]
// general RAM array with one synchronous port
`include "bdmm_defines.svh"
module bdmm_ram (
  input wire logic clk_in,
  input wire logic we_in,
  input wire logic [8:0] addr_in,
  input wire logic [7:0] d_in,
  output logic [7:0] q_out
);
  // contents are not reset, as static RAM
  logic [7:0] mem [0:4*`BDMM_RAM_WORDS-1];
  logic [7:0] q_q;
  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem[addr_in] <= d_in;
    end
    q_q <= mem[addr_in];
  end
  assign q_out = q_q;
endmodule : bdmm_ram

// [verilog/bdmm_reg8.sv]
// one byte register with separate power-on and warm reset values
`include "bdmm_defines.svh"
module bdmm_reg8 #(
  parameter logic [7:0] POR_VAL = 8'h00,
  parameter logic [7:0] KEEP_MASK = 8'h00,
  parameter logic [7:0] WARM_VAL = 8'h00
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic por_in,
  input wire logic we_in,
  input wire logic [7:0] d_in,
  output logic [7:0] q_out
);
  logic [7:0] q_q;
  logic [7:0] q_d;
  always_comb begin
    q_d = q_q;
    if (we_in) begin
      q_d = d_in; // [R1]
    end
  end
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      // keep-mask bits stay unchanged on warm reset
      q_q <= por_in ? POR_VAL : ((q_q & KEEP_MASK) | (WARM_VAL & ~KEEP_MASK)); // [R4]
    end else begin
      q_q <= q_d;
    end
  end
  assign q_out = q_q;
endmodule : bdmm_reg8

// [verilog/bdmm_top.sv]
// core register bank and decoder of the banked data memory, wishbone slave
`include "bdmm_defines.svh"
module bdmm_top (
  // clock and reset
  input wire logic CLOCK_IN,
  input wire logic NRST_IN,
  input wire logic POR_IN,
  // wishbone slave
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [10:0] WB_ADR_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  // core state
  output logic [1:0] BANK_OUT,
  output logic [12:0] PC_OUT
);
  import bdmm_pkg::*;
  typedef struct packed {
    bdmm_state_type st;
    logic ack;
    logic [31:0] dat;
    logic [4:0] pc_hi;
    logic [1:0] bank;
    logic [12:0] pc;
  } bdmm_regs_type;
  bdmm_regs_type r_q;
  bdmm_regs_type r_d;
  logic [7:0] flags_q, ptr_q, pcl_q, latch_q, intc_q, timer0_count_q, peripheral_interrupt_flags_1_q;
  logic [7:0] pa_q, pb_q, pc_port_q, pd_q, pe_q;
  logic [7:0] ram_q;
  logic [7:0] wdat;
  logic req;
  logic wr;
  logic [1:0] bank;
  logic [6:0] ofs;
  logic [8:0] eff;
  logic [6:0] eofs;
  logic [8:0] ram_addr;
  logic is_ram;
  logic [12:0] we_vec;
  logic [7:0] rd_sfr;
  logic rd_ram_q;
  // only byte lane 0 carries the register byte
  assign req = WB_CYC_IN && WB_STB_IN && (r_q.st == BDMM_IDLE) && !r_q.ack;
  assign wr = req && WB_WE_IN && WB_SEL_IN[0];
  assign wdat = WB_DAT_IN[7:0];
  assign bank = flags_q[6:5]; // [R5]
  assign ofs = WB_ADR_IN[8:2];
  always_comb begin
    eff = {bank, ofs}; // [R5]
    if (ofs == `BDMM_OFS_INDIRECT) begin
      // all eight pointer bits plus bank-high flag bit 7 form the address
      eff = {flags_q[7], ptr_q}; // [R3]
    end
  end
  assign eofs = eff[6:0]; // [R6]
  // shared top region always lands in bank 0
  assign ram_addr = (eofs >= `BDMM_OFS_SHARED) ? {2'b00, eofs} : eff; // [R9]
  always_comb begin
    is_ram = 1'b0;
    if (eofs >= `BDMM_OFS_SHARED) begin
      is_ram = 1'b1; // [R9]
    end else if (eofs >= `BDMM_OFS_RAM_LO) begin
      is_ram = (eff[8:7] == 2'b00) || (eofs <= 7'h6f); // [R6]
    end
  end
  // core registers ignore the bank bits
  always_comb begin
    we_vec = '0;
    if (wr && eofs != `BDMM_OFS_INDIRECT) begin
      if (eofs == `BDMM_OFS_PC_LOW) we_vec[0] = 1'b1; // [R7]
      if (eofs == `BDMM_OFS_FLAGS) we_vec[1] = 1'b1; // [R7]
      if (eofs == `BDMM_OFS_POINTER) we_vec[2] = 1'b1; // [R7]
      if (eofs == `BDMM_OFS_PC_LATCH) we_vec[3] = 1'b1; // [R7]
      if (eofs == `BDMM_OFS_INT_CTRL) we_vec[4] = 1'b1; // [R7]
      if (eff[7] == 1'b0) begin
        if (eofs == `BDMM_OFS_TIMER0) we_vec[5] = 1'b1;
        if (eff[8] == 1'b0) begin
          if (eofs == `BDMM_OFS_PORT_A) we_vec[6] = 1'b1;
          if (eofs == `BDMM_OFS_PORT_B) we_vec[7] = 1'b1;
          if (eofs == `BDMM_OFS_PORT_C) we_vec[8] = 1'b1;
          if (eofs == `BDMM_OFS_PORT_D) we_vec[9] = 1'b1;
          if (eofs == `BDMM_OFS_PORT_E) we_vec[10] = 1'b1;
          if (eofs == `BDMM_OFS_PERIPHERAL_INTERRUPT_FLAGS_1) we_vec[11] = 1'b1;
        end
      end
    end
  end
  bdmm_reg8 #(.POR_VAL(`BDMM_ZERO8)) u_pcl (.clk_in(CLOCK_IN), .nrst_in(NRST_IN),
    .por_in(POR_IN), .we_in(we_vec[0]), .d_in(wdat), .q_out(pcl_q));
  bdmm_reg8 #(.POR_VAL(`BDMM_FLAGS_POR), .KEEP_MASK(`BDMM_FLAGS_KEEP), .WARM_VAL(`BDMM_ZERO8))
    u_flags (.clk_in(CLOCK_IN), .nrst_in(NRST_IN), .por_in(POR_IN), .we_in(we_vec[1]),
    .d_in({wdat[7:5], flags_q[4:3], wdat[2:0]}), .q_out(flags_q));
  bdmm_reg8 #(.KEEP_MASK(8'hff)) u_ptr (.clk_in(CLOCK_IN), .nrst_in(NRST_IN),
    .por_in(POR_IN), .we_in(we_vec[2]), .d_in(wdat), .q_out(ptr_q));
  bdmm_reg8 u_latch (.clk_in(CLOCK_IN), .nrst_in(NRST_IN), .por_in(POR_IN),
    .we_in(we_vec[3]), .d_in(wdat & `BDMM_PCL_MASK), .q_out(latch_q));
  bdmm_reg8 #(.KEEP_MASK(`BDMM_INT_KEEP)) u_intc (.clk_in(CLOCK_IN), .nrst_in(NRST_IN),
    .por_in(POR_IN), .we_in(we_vec[4]), .d_in(wdat), .q_out(intc_q));
  bdmm_reg8 u_timer0_count (.clk_in(CLOCK_IN), .nrst_in(NRST_IN), .por_in(POR_IN),
    .we_in(we_vec[5]), .d_in(wdat), .q_out(timer0_count_q));
  bdmm_reg8 #(.KEEP_MASK(8'hff)) u_pa (.clk_in(CLOCK_IN), .nrst_in(NRST_IN),
    .por_in(POR_IN), .we_in(we_vec[6]), .d_in(wdat), .q_out(pa_q));
  bdmm_reg8 #(.KEEP_MASK(8'hff)) u_pb (.clk_in(CLOCK_IN), .nrst_in(NRST_IN),
    .por_in(POR_IN), .we_in(we_vec[7]), .d_in(wdat), .q_out(pb_q));
  bdmm_reg8 #(.KEEP_MASK(8'hff)) u_pc (.clk_in(CLOCK_IN), .nrst_in(NRST_IN),
    .por_in(POR_IN), .we_in(we_vec[8]), .d_in(wdat), .q_out(pc_port_q));
  bdmm_reg8 #(.KEEP_MASK(8'hff)) u_pd (.clk_in(CLOCK_IN), .nrst_in(NRST_IN),
    .por_in(POR_IN), .we_in(we_vec[9]), .d_in(wdat), .q_out(pd_q));
  bdmm_reg8 #(.KEEP_MASK(8'hff)) u_pe (.clk_in(CLOCK_IN), .nrst_in(NRST_IN),
    .por_in(POR_IN), .we_in(we_vec[10]), .d_in(wdat & `BDMM_PORT_E_DATA_MASK), .q_out(pe_q));
  bdmm_reg8 u_peripheral_interrupt_flags_1 (.clk_in(CLOCK_IN), .nrst_in(NRST_IN), .por_in(POR_IN),
    .we_in(we_vec[11]), .d_in(wdat), .q_out(peripheral_interrupt_flags_1_q));
  bdmm_ram u_ram (.clk_in(CLOCK_IN), .we_in(wr && is_ram), .addr_in(ram_addr),
    .d_in(wdat), .q_out(ram_q));
  always_comb begin
    rd_sfr = `BDMM_ZERO8; // [R2]
    unique case (eofs)
      `BDMM_OFS_PC_LOW: rd_sfr = pcl_q;
      `BDMM_OFS_FLAGS: rd_sfr = flags_q;
      `BDMM_OFS_POINTER: rd_sfr = ptr_q;
      `BDMM_OFS_PC_LATCH: rd_sfr = latch_q;
      `BDMM_OFS_INT_CTRL: rd_sfr = intc_q;
      `BDMM_OFS_TIMER0: rd_sfr = eff[7] ? `BDMM_ZERO8 : timer0_count_q;
      `BDMM_OFS_PORT_A: rd_sfr = (eff[8:7] == 2'b00) ? pa_q : `BDMM_ZERO8;
      `BDMM_OFS_PORT_B: rd_sfr = (eff[8:7] == 2'b00) ? pb_q : `BDMM_ZERO8;
      `BDMM_OFS_PORT_C: rd_sfr = (eff[8:7] == 2'b00) ? pc_port_q : `BDMM_ZERO8;
      `BDMM_OFS_PORT_D: rd_sfr = (eff[8:7] == 2'b00) ? pd_q : `BDMM_ZERO8;
      `BDMM_OFS_PORT_E: rd_sfr = (eff[8:7] == 2'b00) ? pe_q : `BDMM_ZERO8;
      `BDMM_OFS_PERIPHERAL_INTERRUPT_FLAGS_1: rd_sfr = (eff[8:7] == 2'b00) ? peripheral_interrupt_flags_1_q : `BDMM_ZERO8;
      default: rd_sfr = `BDMM_ZERO8; // [R2]
    endcase
  end
  // ram answers one cycle later, so every read is acked after two cycles
  logic [7:0] sfr_hold_q;
  always_ff @(posedge CLOCK_IN) begin
    rd_ram_q <= is_ram;
    sfr_hold_q <= rd_sfr;
  end
  always_comb begin
    r_d = r_q;
    r_d.ack = 1'b0;
    unique case (r_q.st)
      BDMM_IDLE: begin
        if (req) begin
          r_d.st = BDMM_ACK;
          if (we_vec[0]) begin
            r_d.pc = {r_q.pc_hi, wdat}; // [R8]
          end
        end
      end
      BDMM_ACK: begin
        r_d.st = BDMM_IDLE;
        r_d.ack = 1'b1;
        r_d.dat = {24'h00_0000, rd_ram_q ? ram_q : sfr_hold_q};
      end
    endcase
    r_d.pc_hi = latch_q[4:0]; // [R8]
    r_d.bank = bank;
  end
  always_ff @(posedge CLOCK_IN) begin
    if (!NRST_IN) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end
  assign WB_ACK_OUT = r_q.ack;
  assign WB_DAT_OUT = r_q.dat;
  assign BANK_OUT = r_q.bank;
  assign PC_OUT = r_q.pc;
  pc_load_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // [R8]
    we_vec[0] |=> r_q.pc == {$past(latch_q[4:0]), $past(wdat)})
    else $error("counter not loaded from latch");
  latch_only_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // [R8]
    (we_vec[3] && !we_vec[0]) |=> $stable(r_q.pc))
    else $error("latch write moved counter");
  ack_time_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // [R2]
    req |-> ##2 WB_ACK_OUT) else $error("ack late");
  ack_pulse_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // [R1]
    WB_ACK_OUT |=> !WB_ACK_OUT) else $error("ack held");
  bank_sel_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // [R5]
    1'b1 |=> BANK_OUT == $past(flags_q[6:5])) else $error("bank wrong");
  shared_map_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // [R9]
    (req && eofs >= `BDMM_OFS_SHARED) |-> ram_addr[8:7] == 2'b00)
    else $error("shared ram not bank 0");
  indirect_map_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // [R3]
    (req && ofs == `BDMM_OFS_INDIRECT) |-> eff == {flags_q[7], ptr_q})
    else $error("indirect not redirected");
  flags_por_a: assert property (@(posedge CLOCK_IN) // [R4]
    (!NRST_IN && POR_IN) |=> flags_q == `BDMM_FLAGS_POR) else $error("flags por");
  unmapped_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // [R2]
    (req && !is_ram && eofs > `BDMM_OFS_PERIPHERAL_INTERRUPT_FLAGS_1) |-> ##2 WB_DAT_OUT == 32'h0000_0000)
    else $error("unmapped read nonzero");
endmodule : bdmm_top
